// ---- logic/fault_detection_manager.sv ----
// fault detection manager: fault flags, corrective actions, interrupt source coding
// assumes fault inputs are analog comparator levels from outside the pclk domain
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - regulator warm sets supply bit1, code 0101
// - regulator overheat: off, reset, then sleep
// - reset with vdd low, supply_undervoltage_flag clear: sleep
// - txd low too long: transmitter off, code 0100
// - bus driver overheat: transmitter off, flag
// - switch overheat: both off, code 0010
// - switch overheat sets all switch flags
// - switches stay off until control write
// - current limit flags follow condition live
// - watchdog expiry or early clear resets host
// - floating config pin: fallback timebase, error flag
// - interrupts only in normal, request, stop
// - masked source: line high, no flag
// - overvoltage switch shutdown only with enable
// - transmitter re-enables when clear, txd high
// - bus status read clears absent rx short
module fault_detection_manager #(
	parameter longint TX_STUCK_DOMINANT_FLAG_CYC = fault_mgr_pkg::TX_STUCK_DOMINANT_FLAG_CYCLES,
	parameter longint WD_CYC    = fault_mgr_pkg::WD_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        reg_ot_warn,
	input  wire logic        reg_ot_shutdown,
	input  wire logic        vdd_undervoltage,
	input  wire logic        supply_undervoltage,
	input  wire logic        supply_overvoltage,
	input  wire logic        txd_in,
	input  wire logic        rx_short,
	input  wire logic        bus_driver_ot,
	input  wire logic        switch_ot,
	input  wire logic        switch1_overcurrent,
	input  wire logic        switch2_overcurrent,
	input  wire logic        watchdog_config_pin_floating,
	input  wire logic        stop_mode,
	output logic             irq_n,
	output logic [3:0]       irq_code,
	output logic             host_reset_n,
	output logic             regulator_en,
	output logic             bus_tx_en,
	output logic [1:0]       switch_en,
	output logic             wd_fallback_timebase
);
	typedef logic [12:0] sync_t;
	sync_t s2_r;
	sync_t raw;
	assign raw = {stop_mode, watchdog_config_pin_floating, switch2_overcurrent,
		switch1_overcurrent, switch_ot, bus_driver_ot, rx_short, txd_in,
		supply_overvoltage, supply_undervoltage, vdd_undervoltage,
		reg_ot_shutdown, reg_ot_warn};
	sync_t meta_r;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			// only txd_in idles high (recessive)
			meta_r <= 13'h0020;
			s2_r   <= 13'h0020;
		end
		else
		begin
			meta_r <= raw;
			s2_r   <= meta_r;
		end

	wire i_warn  = s2_r[0];
	wire i_shut  = s2_r[1];
	wire i_vddlo = s2_r[2];
	wire i_suvlo = s2_r[3];
	wire i_ov    = s2_r[4];
	wire i_txd   = s2_r[5];
	wire i_rxs   = s2_r[6];
	wire i_bot   = s2_r[7];
	wire i_sot   = s2_r[8];
	wire i_oc1   = s2_r[9];
	wire i_oc2   = s2_r[10];
	wire i_wdflt = s2_r[11];
	wire i_stop  = s2_r[12];

	fault_mgr_pkg::op_mode_t mode_r, mode_nxt;
	logic [31:0] rst_cnt_r;
	logic        shut_seq_r;
	logic [63:0] wd_cnt_r, txd_cnt_r;
	logic        tx_stuck_dominant_flag_r, rxs_r, bot_r, suv_r, sov_r, watchdog_timeout_flag_r, watchdog_error_flag_r;
	logic        high_voltage_shutdown_enable_r, sw_lock_r;
	logic        tx_off_r;
	logic [1:0]  sw_ctl_r;
	logic [2:0]  irq_stat_r, irq_mask_r;

	wire apb_acc = psel && penable;
	wire wr      = apb_acc && pwrite;
	wire rd      = apb_acc && !pwrite;
	wire wr_sw   = wr && (paddr == fault_mgr_pkg::ADDR_SWITCH_CONTROL);
	wire wr_mode = wr && (paddr == fault_mgr_pkg::ADDR_MODE_CONTROL);
	wire wr_ist  = wr && (paddr == fault_mgr_pkg::ADDR_IRQ_STATUS);
	wire wr_msk  = wr && (paddr == fault_mgr_pkg::ADDR_IRQ_MASK);
	wire wr_wd   = wr && (paddr == fault_mgr_pkg::ADDR_WD_CLEAR);
	wire rd_bus  = rd && (paddr == fault_mgr_pkg::ADDR_BUS_STATUS);
	wire mapped  = (paddr <= fault_mgr_pkg::ADDR_WD_CLEAR) && (paddr[1:0] == 2'b00);

	wire irq_ok    = (mode_r == fault_mgr_pkg::MODE_NORMAL)
		|| (mode_r == fault_mgr_pkg::MODE_NREQ) || i_stop;
	wire normal    = mode_r == fault_mgr_pkg::MODE_NORMAL;
	wire lin_mode  = normal || (mode_r == fault_mgr_pkg::MODE_NREQ);
	wire wd_half   = wd_cnt_r >= (WD_CYC / 2);
	wire wd_fault  = normal && ((wd_cnt_r >= WD_CYC - 1) || (wr_wd && !wd_half));
	wire txd_stuck = lin_mode && !i_txd && (txd_cnt_r >= TX_STUCK_DOMINANT_FLAG_CYC - 1);
	wire tx_hit    = txd_stuck || i_bot || i_rxs;
	wire tx_clear  = i_txd && !i_bot && !i_rxs;
	wire bus_fault = tx_off_r || i_bot || i_rxs;
	wire sw_kill   = i_sot || (normal && i_ov && high_voltage_shutdown_enable_r);

	wire [2:0] ev = {i_sot, txd_stuck || i_bot || (i_rxs && !rxs_r),
		i_warn || i_suvlo || i_ov};
	wire [2:0] ev_set = ev & irq_mask_r & {3{irq_ok}};
	wire [2:0] ist_nxt = (irq_stat_r & ~(wr_ist ? pwdata[2:0] : 3'h0)) | ev_set;

	always_comb
	begin
		mode_nxt = mode_r;
		case (mode_r)
			fault_mgr_pkg::MODE_RESET:
				if (i_vddlo && !i_suvlo)
					mode_nxt = fault_mgr_pkg::MODE_SLEEP;
				else if (rst_cnt_r >= fault_mgr_pkg::RST_PULSE_CYC)
					mode_nxt = shut_seq_r ? fault_mgr_pkg::MODE_SLEEP : fault_mgr_pkg::MODE_NREQ;
			fault_mgr_pkg::MODE_NREQ:
				if (wr_mode && pwdata[1])
					mode_nxt = fault_mgr_pkg::MODE_NORMAL;
			fault_mgr_pkg::MODE_NORMAL:
				if (wd_fault)
					mode_nxt = fault_mgr_pkg::MODE_RESET;
			fault_mgr_pkg::MODE_SLEEP:
				mode_nxt = fault_mgr_pkg::MODE_SLEEP;
			default:
				mode_nxt = fault_mgr_pkg::MODE_RESET;
		endcase
		if (i_shut && mode_r != fault_mgr_pkg::MODE_SLEEP)
			mode_nxt = fault_mgr_pkg::MODE_RESET;
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mode_r     <= fault_mgr_pkg::MODE_RESET;
			rst_cnt_r  <= 32'h0;
			shut_seq_r <= 1'b0;
		end
		else
		begin
			mode_r     <= mode_nxt;
			rst_cnt_r  <= (mode_r == fault_mgr_pkg::MODE_RESET) ? rst_cnt_r + 32'h1 : 32'h0;
			shut_seq_r <= shut_seq_r || i_shut;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			wd_cnt_r  <= 64'h0;
			txd_cnt_r <= 64'h0;
			watchdog_timeout_flag_r    <= 1'b0;
			watchdog_error_flag_r   <= 1'b0;
		end
		else
		begin
			wd_cnt_r  <= (!normal || wr_wd) ? 64'h0 : wd_cnt_r + 64'h1;
			txd_cnt_r <= (i_txd || !lin_mode) ? 64'h0 : txd_cnt_r + 64'h1;
			watchdog_timeout_flag_r    <= watchdog_timeout_flag_r || wd_fault;
			watchdog_error_flag_r   <= i_wdflt;
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tx_stuck_dominant_flag_r <= 1'b0;
			rxs_r   <= 1'b0;
			bot_r   <= 1'b0;
			tx_off_r <= 1'b0;
		end
		else
		begin
			tx_stuck_dominant_flag_r <= txd_stuck || (tx_stuck_dominant_flag_r && !(i_txd && rd_bus));
			rxs_r   <= i_rxs || (rxs_r && !rd_bus);
			bot_r   <= i_bot;
			// shutdown latch is separate from the read-cleared flags
			tx_off_r <= tx_hit || (tx_off_r && !tx_clear);
		end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			suv_r      <= 1'b0;
			sov_r      <= 1'b0;
			high_voltage_shutdown_enable_r     <= 1'b0;
			sw_ctl_r   <= 2'b00;
			sw_lock_r  <= 1'b0;
			irq_stat_r <= 3'h0;
			irq_mask_r <= fault_mgr_pkg::RESET_MASK;
		end
		else
		begin
			suv_r      <= i_suvlo;
			sov_r      <= i_ov;
			high_voltage_shutdown_enable_r     <= wr_mode ? pwdata[fault_mgr_pkg::BIT_MODE_HIGH_VOLTAGE_SHUTDOWN_ENABLE] : high_voltage_shutdown_enable_r;
			sw_ctl_r   <= wr_sw ? pwdata[1:0] : sw_ctl_r;
			sw_lock_r  <= sw_kill || (sw_lock_r && !wr_sw);
			irq_stat_r <= ist_nxt;
			irq_mask_r <= wr_msk ? pwdata[2:0] : irq_mask_r;
		end

	wire [31:0] sup_word = {28'h0, sov_r, suv_r, i_warn, 1'b0};
	wire [31:0] bus_word = {28'h0, rxs_r, tx_stuck_dominant_flag_r, bot_r, 1'b0};
	wire [31:0] sw_word  = i_sot ? 32'h0000000F
		: {28'h0, 1'b0, i_oc2, 1'b0, i_oc1};
	wire [31:0] wd_word  = {28'h0, watchdog_timeout_flag_r, watchdog_error_flag_r, 2'b00};
	wire [3:0]  code     = irq_stat_r[fault_mgr_pkg::IRQ_SUPPLY] ? fault_mgr_pkg::CODE_SUPPLY
		: irq_stat_r[fault_mgr_pkg::IRQ_BUS] ? fault_mgr_pkg::CODE_BUS
		: irq_stat_r[fault_mgr_pkg::IRQ_SWITCH] ? fault_mgr_pkg::CODE_SWITCH
		: fault_mgr_pkg::CODE_NONE;

	wire [31:0] rd_mux =
		(paddr == fault_mgr_pkg::ADDR_SUPPLY_STATUS)   ? sup_word :
		(paddr == fault_mgr_pkg::ADDR_BUS_STATUS)      ? bus_word :
		(paddr == fault_mgr_pkg::ADDR_SWITCH_STATUS)   ? sw_word :
		(paddr == fault_mgr_pkg::ADDR_WATCHDOG_STATUS) ? wd_word :
		(paddr == fault_mgr_pkg::ADDR_SWITCH_CONTROL)  ? {30'h0, sw_ctl_r} :
		(paddr == fault_mgr_pkg::ADDR_MODE_CONTROL)    ? {31'h0, high_voltage_shutdown_enable_r} :
		(paddr == fault_mgr_pkg::ADDR_IRQ_SOURCE)      ? {28'h0, code} :
		(paddr == fault_mgr_pkg::ADDR_IRQ_STATUS)      ? {29'h0, irq_stat_r} :
		(paddr == fault_mgr_pkg::ADDR_IRQ_MASK)        ? {29'h0, irq_mask_r} : 32'h0;

	assign prdata  = rd_mux;
	assign pready  = 1'b1;
	assign pslverr = apb_acc && !mapped;

	assign irq_n        = ~|(irq_stat_r & irq_mask_r);
	assign irq_code     = code;
	assign host_reset_n = (mode_r != fault_mgr_pkg::MODE_RESET);
	assign regulator_en = !shut_seq_r && (mode_r != fault_mgr_pkg::MODE_SLEEP);
	assign bus_tx_en    = lin_mode && !bus_fault;
	assign switch_en    = (sw_lock_r || i_sot) ? 2'b00 : sw_ctl_r;
	assign wd_fallback_timebase = watchdog_error_flag_r;

	chk_warn_irq_code: assert property (@(posedge pclk) disable iff (!presetn)
		(i_warn && irq_ok && irq_mask_r[0]) |=> (irq_code == 4'h5) && !irq_n)
		else $error("regulator warning did not raise code 0101");
	chk_shut_seq: assert property (@(posedge pclk) disable iff (!presetn)
		(i_shut && mode_r == fault_mgr_pkg::MODE_NORMAL) |=> !regulator_en && !host_reset_n)
		else $error("overheat shutdown did not cut regulator and reset");
	chk_reset_sleep: assert property (@(posedge pclk) disable iff (!presetn)
		(mode_r == fault_mgr_pkg::MODE_RESET && i_vddlo && !i_suvlo && !i_shut)
		|=> mode_r == fault_mgr_pkg::MODE_SLEEP)
		else $error("reset with low vdd did not go to sleep");
	chk_tx_stuck_dominant_flag_off: assert property (@(posedge pclk) disable iff (!presetn)
		txd_stuck |=> tx_stuck_dominant_flag_r && !bus_tx_en)
		else $error("stuck dominant not handled");
	chk_busot_off: assert property (@(posedge pclk) disable iff (!presetn)
		i_bot |-> !bus_tx_en)
		else $error("transmitter on during driver overheat");
	sequence sw_hot_quiet;
		i_sot ##1 !wr_sw;
	endsequence
	chk_sw_ot_off: assert property (@(posedge pclk) disable iff (!presetn)
		sw_hot_quiet |-> (switch_en == 2'b00) ##1 (switch_en == 2'b00))
		else $error("switches on after overheat");
	chk_sw_lock: assert property (@(posedge pclk) disable iff (!presetn)
		(sw_lock_r && !wr_sw && !$past(wr_sw)) |=> switch_en == 2'b00)
		else $error("switches re-enabled without control write");
	chk_irq_mode: assert property (@(posedge pclk) disable iff (!presetn)
		(!irq_ok && irq_stat_r == 3'h0 && !wr_msk) |=> irq_stat_r == 3'h0)
		else $error("interrupt flag set outside allowed modes");
	chk_masked_line: assert property (@(posedge pclk) disable iff (!presetn)
		(irq_mask_r == 3'h0) |-> irq_n)
		else $error("masked interrupt pulled the line low");
	sequence tx_clear_seq;
		lin_mode && tx_clear;
	endsequence
	chk_tx_reenable: assert property (@(posedge pclk) disable iff (!presetn)
		tx_clear_seq ##1 (lin_mode && !i_bot && !i_rxs) |-> bus_tx_en)
		else $error("transmitter not re-enabled after fault cleared");
	chk_rxs_hold: assert property (@(posedge pclk) disable iff (!presetn)
		i_rxs |=> rxs_r)
		else $error("rx short flag cleared while short present");
	chk_sw_flags_all: assert property (@(posedge pclk) disable iff (!presetn)
		(i_sot && paddr == fault_mgr_pkg::ADDR_SWITCH_STATUS) |-> prdata[3:0] == 4'hF)
		else $error("switch overheat did not set all switch flags");
	chk_wd_timeout: assert property (@(posedge pclk) disable iff (!presetn)
		wd_fault |=> !host_reset_n && watchdog_timeout_flag_r)
		else $error("watchdog fault did not reset host");
	chk_wd_fallback: assert property (@(posedge pclk) disable iff (!presetn)
		i_wdflt |=> wd_fallback_timebase)
		else $error("floating config pin did not select fallback timebase");
	chk_ov_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(i_ov && !high_voltage_shutdown_enable_r && !i_sot && !sw_lock_r) |=> !sw_lock_r)
		else $error("overvoltage shut switches without enable");
endmodule : fault_detection_manager

`default_nettype wire

// ---- include/fault_mgr_pkg.sv ----
// constants for the fault detection manager: register offsets, bit positions, codes
// assumes an apb slave with 32-bit aligned words and a 200 MHz pclk
package fault_mgr_pkg;
	localparam logic [7:0] ADDR_SUPPLY_STATUS   = 8'h00;
	localparam logic [7:0] ADDR_BUS_STATUS      = 8'h04;
	localparam logic [7:0] ADDR_SWITCH_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_WATCHDOG_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_SWITCH_CONTROL  = 8'h10;
	localparam logic [7:0] ADDR_MODE_CONTROL    = 8'h14;
	localparam logic [7:0] ADDR_IRQ_SOURCE      = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STATUS      = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_MASK        = 8'h20;
	localparam logic [7:0] ADDR_WD_CLEAR        = 8'h24;

	localparam int BIT_SUP_REG_OT  = 1;
	localparam int BIT_SUP_UV      = 2;
	localparam int BIT_SUP_OV      = 3;
	localparam int BIT_BUS_OT      = 1;
	localparam int BIT_BUS_TX_STUCK_DOMINANT_FLAG   = 2;
	localparam int BIT_BUS_RX_PIN_SHORT_FLAG = 3;
	localparam int BIT_SW1_CL      = 0;
	localparam int BIT_SW2_CL      = 2;
	localparam int BIT_WD_ERR      = 2;
	localparam int BIT_WD_TO       = 3;
	localparam int BIT_MODE_HIGH_VOLTAGE_SHUTDOWN_ENABLE   = 0;

	// interrupt status bits (sticky, write one to clear)
	localparam int IRQ_SUPPLY = 0;
	localparam int IRQ_BUS    = 1;
	localparam int IRQ_SWITCH = 2;

	localparam logic [3:0] CODE_SUPPLY = 4'h5;
	localparam logic [3:0] CODE_BUS    = 4'h4;
	localparam logic [3:0] CODE_SWITCH = 4'h2;
	localparam logic [3:0] CODE_NONE   = 4'h0;

	localparam logic [2:0] RESET_MASK = 3'h7;

	localparam longint CLK_HZ          = 200000000;
	localparam longint TX_STUCK_DOMINANT_FLAG_LIMIT_MS  = 1000;
	localparam longint TX_STUCK_DOMINANT_FLAG_CYCLES    = TX_STUCK_DOMINANT_FLAG_LIMIT_MS * CLK_HZ / 1000;
	localparam longint WD_PERIOD_MS    = 150;
	localparam longint WD_CYCLES       = WD_PERIOD_MS * CLK_HZ / 1000;
	localparam int     RST_PULSE_CYC   = 16;

	typedef enum logic [3:0] {
		MODE_RESET  = 4'h1,
		MODE_NREQ   = 4'h2,
		MODE_NORMAL = 4'h4,
		MODE_SLEEP  = 4'h8
	} op_mode_t;
endpackage : fault_mgr_pkg

// ---- dv/fault_host_model.sv ----
// host model: apb master that reads and writes the fault manager registers
// assumes one pclk domain; pready is sampled only at rising edges
`timescale 1ns/10ps
`default_nettype none
module fault_host_model (
	input  wire logic        pclk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata
);
	logic last_err;
	logic hung;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		last_err = 1'b0;
		hung = 1'b0;
	end
	// one transfer per call in any device mode; hung is set if pready stays low for 50 cycles
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1)
			hung = 1'b1;
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : fault_host_model
`default_nettype wire

// ---- dv/fault_detection_manager_tb.sv ----
// testbench: fault inputs driven directly, registers reached through the host model
// assumes watchdog and stuck-dominant counts shortened by parameter
`timescale 1ns/10ps
`default_nettype none
module fault_detection_manager_tb;
	logic pclk = 1'b0, presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic warn = 0, shut = 0, vdd_uv = 0, sup_uv = 0, ov = 0, txd = 1, rxs = 0, bot = 0;
	logic sot = 0, oc1 = 0, oc2 = 0, flt = 1, stop = 0;
	logic irq_n, host_reset_n, regulator_en, bus_tx_en, wd_fallback_timebase;
	logic [3:0] irq_code;
	logic [1:0] switch_en;
	int mismatches = 0, checks = 0;
	always #2.5 pclk = ~pclk;
	fault_detection_manager #(.TX_STUCK_DOMINANT_FLAG_CYC(64), .WD_CYC(4000)) fault_detection_manager_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reg_ot_warn(warn), .reg_ot_shutdown(shut), .vdd_undervoltage(vdd_uv),
		.supply_undervoltage(sup_uv), .supply_overvoltage(ov), .txd_in(txd), .rx_short(rxs),
		.bus_driver_ot(bot), .switch_ot(sot), .switch1_overcurrent(oc1),
		.switch2_overcurrent(oc2), .watchdog_config_pin_floating(flt), .stop_mode(stop),
		.irq_n(irq_n), .irq_code(irq_code), .host_reset_n(host_reset_n),
		.regulator_en(regulator_en), .bus_tx_en(bus_tx_en), .switch_en(switch_en),
		.wd_fallback_timebase(wd_fallback_timebase));
	fault_host_model fault_host_model_inst (.pclk(pclk), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		fault_host_model_inst.xfer(wr, a, d, q);
		if (fault_host_model_inst.hung)
		begin
			mismatches++;
			print_verdict();
		end
	endtask : acc
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), e, q);
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick
	task automatic wait_rst(input logic v);
		int n;
		for (n = 0; n < 60 && host_reset_n !== v; n++)
			@(posedge pclk);
		chk("host_reset_n", v, host_reset_n);
		if (host_reset_n !== v)
			print_verdict();
	endtask : wait_rst
	initial
	begin
		tick(6);
		presetn <= 1'b1;
		tick(1);
		chk("irq_n", 1, irq_n);
		wait_rst(1);
		acc(1, fault_mgr_pkg::ADDR_MODE_CONTROL, 32'h2);
		acc(1, fault_mgr_pkg::ADDR_WD_CLEAR, 32'h1);
		wait_rst(0);
		wait_rst(1);
		rd(fault_mgr_pkg::ADDR_WATCHDOG_STATUS, 32'hC);
		chk("fallback", 1, wd_fallback_timebase);
		acc(1, fault_mgr_pkg::ADDR_MODE_CONTROL, 32'h2);
		rd(8'h30, 32'h0);
		chk("pslverr", 1, fault_host_model_inst.last_err);
		acc(1, fault_mgr_pkg::ADDR_IRQ_MASK, 32'h6);
		warn <= 1'b1;
		tick(4);
		chk("masked irq_n", 1, irq_n);
		rd(fault_mgr_pkg::ADDR_IRQ_STATUS, 32'h0);
		acc(1, fault_mgr_pkg::ADDR_IRQ_MASK, 32'h7);
		tick(4);
		chk("irq_n", 0, irq_n);
		chk("code", 4'h5, irq_code);
		rd(fault_mgr_pkg::ADDR_SUPPLY_STATUS, 32'h2);
		warn <= 1'b0;
		tick(4);
		rd(fault_mgr_pkg::ADDR_SUPPLY_STATUS, 32'h0);
		acc(1, fault_mgr_pkg::ADDR_IRQ_STATUS, 32'h1);
		tick(1);
		chk("irq_n", 1, irq_n);
		txd <= 1'b0;
		tick(80);
		chk("tx_en", 0, bus_tx_en);
		chk("code", 4'h4, irq_code);
		rd(fault_mgr_pkg::ADDR_BUS_STATUS, 32'h4);
		txd <= 1'b1;
		tick(4);
		chk("tx_en", 1, bus_tx_en);
		rd(fault_mgr_pkg::ADDR_BUS_STATUS, 32'h4);
		rd(fault_mgr_pkg::ADDR_BUS_STATUS, 32'h0);
		bot <= 1'b1;
		tick(4);
		chk("tx_en", 0, bus_tx_en);
		rd(fault_mgr_pkg::ADDR_BUS_STATUS, 32'h2);
		bot <= 1'b0;
		rxs <= 1'b1;
		tick(4);
		rd(fault_mgr_pkg::ADDR_BUS_STATUS, 32'h8);
		rd(fault_mgr_pkg::ADDR_BUS_STATUS, 32'h8);
		rxs <= 1'b0;
		tick(4);
		rd(fault_mgr_pkg::ADDR_BUS_STATUS, 32'h8);
		rd(fault_mgr_pkg::ADDR_BUS_STATUS, 32'h0);
		acc(1, fault_mgr_pkg::ADDR_IRQ_STATUS, 32'h2);
		acc(1, fault_mgr_pkg::ADDR_SWITCH_CONTROL, 32'h3);
		tick(2);
		chk("sw_en", 2'h3, switch_en);
		sot <= 1'b1;
		tick(4);
		chk("sw_en", 2'h0, switch_en);
		chk("code", 4'h2, irq_code);
		rd(fault_mgr_pkg::ADDR_SWITCH_STATUS, 32'hF);
		sot <= 1'b0;
		tick(8);
		chk("sw_en", 2'h0, switch_en);
		acc(1, fault_mgr_pkg::ADDR_SWITCH_CONTROL, 32'h3);
		tick(2);
		chk("sw_en", 2'h3, switch_en);
		acc(1, fault_mgr_pkg::ADDR_IRQ_STATUS, 32'h4);
		oc1 <= 1'b1;
		tick(4);
		rd(fault_mgr_pkg::ADDR_SWITCH_STATUS, 32'h1);
		chk("sw_en", 2'h3, switch_en);
		oc1 <= 1'b0;
		oc2 <= 1'b1;
		tick(4);
		rd(fault_mgr_pkg::ADDR_SWITCH_STATUS, 32'h4);
		oc2 <= 1'b0;
		tick(4);
		rd(fault_mgr_pkg::ADDR_SWITCH_STATUS, 32'h0);
		ov <= 1'b1;
		tick(4);
		chk("sw_en", 2'h3, switch_en);
		acc(1, fault_mgr_pkg::ADDR_MODE_CONTROL, 32'h1);
		tick(2);
		chk("sw_en", 2'h0, switch_en);
		ov <= 1'b0;
		acc(1, fault_mgr_pkg::ADDR_IRQ_STATUS, 32'h7);
		shut <= 1'b1;
		tick(4);
		chk("reg_en", 0, regulator_en);
		chk("host_reset_n", 0, host_reset_n);
		warn <= 1'b1;
		tick(40);
		chk("reg_en", 0, regulator_en);
		chk("irq_n", 1, irq_n);
		rd(fault_mgr_pkg::ADDR_IRQ_STATUS, 32'h0);
		presetn <= 1'b0;
		shut <= 1'b0;
		vdd_uv <= 1'b1;
		tick(2);
		presetn <= 1'b1;
		tick(1);
		chk("irq_n", 1, irq_n);
		chk("reg_en", 1, regulator_en);
		tick(5);
		chk("reg_en", 0, regulator_en);
		chk("host_reset_n", 1, host_reset_n);
		print_verdict();
	end
endmodule : fault_detection_manager_tb
`default_nettype wire
